/* File: shared/soa_pkg.sv */
`default_nettype none
package soa_pkg;

  // ****************************************************************
  // Parameter word indices
  // ****************************************************************
  localparam logic [1:0] IDX_SEL_A    = 2'h0;
  localparam logic [1:0] IDX_SEL_B    = 2'h1;
  localparam logic [1:0] IDX_SEL_C    = 2'h2;
  localparam logic [1:0] IDX_POLARITY = 2'h3;
  localparam int unsigned NUM_WORDS   = 4;
  localparam logic [1:0] LAST_IDX     = 2'h3;

  // ****************************************************************
  // Factory values
  // ****************************************************************
  localparam logic [15:0] RST_SEL_A    = 16'h0200;
  localparam logic [15:0] RST_SEL_B    = 16'h0000;
  localparam logic [15:0] RST_SEL_C    = 16'h0000;
  localparam logic [15:0] RST_POLARITY = 16'h0000;

  // ****************************************************************
  // Status bit positions on status_in / status_valid
  // ****************************************************************
  localparam int unsigned ST_POS_DONE   = 0;
  localparam int unsigned ST_SPD_MATCH  = 1;
  localparam int unsigned ST_ROTATION   = 2;
  localparam int unsigned ST_SRV_READY  = 3;
  localparam int unsigned ST_TRQ_LIMIT  = 4;
  localparam int unsigned ST_SPD_LIMIT  = 5;
  localparam int unsigned ST_BRAKE      = 6;
  localparam int unsigned ST_WARNING    = 7;
  localparam int unsigned ST_NEAR       = 8;
  localparam int unsigned ST_PULSE_MULT = 9;
  localparam int unsigned NUM_STATUS    = 10;

  // ****************************************************************
  // Selector digit positions (digit n is bits 4n+3:4n)
  // ****************************************************************
  localparam int unsigned DIG_NEAR       = 0;
  localparam int unsigned DIG_PULSE_MULT = 2;
  localparam int unsigned DIG_WIDTH      = 4;
  localparam logic [3:0]  SEL_NONE       = 4'h0;
  localparam logic [3:0]  SEL_OUT1       = 4'h1;
  localparam logic [3:0]  SEL_OUT2       = 4'h2;
  localparam logic [3:0]  SEL_OUT3       = 4'h3;
  localparam int unsigned NUM_OUTS       = 3;
  localparam int unsigned NUM_INPUTS     = 8;

  // Load takes one read per word plus one capture cycle
  localparam int unsigned LOAD_CYCLES = NUM_WORDS + 1;

endpackage : soa_pkg
`default_nettype wire

/* File: shared/soa_store_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface soa_store_if;
  logic        wr_en;
  logic [1:0]  wr_addr;
  logic [15:0] wr_data;
  logic        rd_en;
  logic [1:0]  rd_addr;
  logic [15:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface : soa_store_if
`default_nettype wire

/* File: rtl/soa_param_store.sv */
`timescale 1ns/100ps
`default_nettype none
module soa_param_store (
  input  wire logic  core_clk,
  input  wire logic  store_rst_n,
  soa_store_if.mem   st
);

  // Survives rst_n on purpose: only store_rst_n restores factory values
  logic [15:0] mem_q [soa_pkg::NUM_WORDS];
  logic [15:0] mem_d [soa_pkg::NUM_WORDS];
  logic [15:0] rd_q;
  logic [15:0] rd_d;

  always_comb begin
    mem_d = mem_q;
    rd_d  = rd_q;
    if (st.wr_en) begin
      mem_d[st.wr_addr] = st.wr_data;
    end
    if (st.rd_en) begin
      rd_d = mem_q[st.rd_addr];
    end
  end

  always_ff @(posedge core_clk or negedge store_rst_n) begin
    if (!store_rst_n) begin
      mem_q[soa_pkg::IDX_SEL_A]    <= soa_pkg::RST_SEL_A;
      mem_q[soa_pkg::IDX_SEL_B]    <= soa_pkg::RST_SEL_B;
      mem_q[soa_pkg::IDX_SEL_C]    <= soa_pkg::RST_SEL_C;
      mem_q[soa_pkg::IDX_POLARITY] <= soa_pkg::RST_POLARITY;
      rd_q                         <= 16'h0000;
    end else begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
    end
  end

  assign st.rd_data = rd_q;

endmodule : soa_param_store
`default_nettype wire

/* File: rtl/soa_allocator.sv */
`timescale 1ns/100ps
`default_nettype none
module soa_allocator (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        store_rst_n,
  input  wire logic        prm_wr_en,
  input  wire logic [1:0]  prm_addr,
  input  wire logic [15:0] prm_wr_data,
  input  wire logic        prm_rd_en,
  output var  logic [15:0] prm_rd_data,
  output var  logic        prm_rd_valid,
  input  wire logic [9:0]  status_in,
  input  wire logic [9:0]  status_valid,
  input  wire logic        sink_wiring,
  input  wire logic [7:0]  seq_in_raw,
  output var  logic [7:0]  seq_in_active,
  output var  logic [2:0]  seq_out,
  output var  logic [2:0]  output_status_monitor,
  output var  logic        cfg_ready
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [0:0] {SOA_LOAD, SOA_RUN} soa_state_e;

  soa_state_e  st_q, st_d;
  logic [1:0]  idx_q, idx_d;
  logic        pend_q, pend_d;
  logic [1:0]  pend_idx_q, pend_idx_d;
  logic        host_q, host_d;
  logic [15:0] act_q [soa_pkg::NUM_WORDS];
  logic [15:0] act_d [soa_pkg::NUM_WORDS];
  logic        rdv_q, rdv_d;
  logic        ready_q, ready_d;
  logic [2:0]  out_q, out_d;
  logic [2:0]  mon_q, mon_d;
  logic [7:0]  in_q, in_d;
  logic [2:0]  raw;
  logic [3:0]  dg;

  soa_store_if st ();

  soa_param_store u_store (
    .core_clk    (core_clk),
    .store_rst_n (store_rst_n),
    .st          (st)
  );

  // ****************************************************************
  // Selector lookup
  // ****************************************************************
  function automatic logic [3:0] soa_pick(input logic [15:0] wa,
                                          input logic [15:0] wb,
                                          input logic [15:0] wc,
                                          input int unsigned i);
    logic [3:0] r;
    r = soa_pkg::SEL_NONE;
    if (i < 4) begin
      r = wa[i*soa_pkg::DIG_WIDTH +: 4];
    end else if (i < 8) begin
      r = wb[(i-4)*soa_pkg::DIG_WIDTH +: 4];
    end else if (i == soa_pkg::ST_NEAR) begin
      r = wc[soa_pkg::DIG_NEAR*soa_pkg::DIG_WIDTH +: 4];
    end else if (i == soa_pkg::ST_PULSE_MULT) begin
      r = wc[soa_pkg::DIG_PULSE_MULT*soa_pkg::DIG_WIDTH +: 4];
    end
    return r;
  endfunction : soa_pick

  // ****************************************************************
  // Routing
  // ****************************************************************
  always_comb begin
    raw = 3'h0;
    dg  = soa_pkg::SEL_NONE;
    for (int unsigned i = 0; i < soa_pkg::NUM_STATUS; i++) begin
      dg = soa_pick(act_q[soa_pkg::IDX_SEL_A], act_q[soa_pkg::IDX_SEL_B],
                    act_q[soa_pkg::IDX_SEL_C], i);
      for (int unsigned k = 0; k < soa_pkg::NUM_OUTS; k++) begin
        // Zero and values above 3 hit no output
        if (status_valid[i] && status_in[i] && dg == 4'(k + 1)) begin
          raw[k] = 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Load at power-up, host reads, outputs
  // ****************************************************************
  always_comb begin
    st_d       = st_q;
    idx_d      = idx_q;
    pend_d     = 1'b0;
    pend_idx_d = pend_idx_q;
    host_d     = 1'b0;
    act_d      = act_q;
    st.rd_en   = 1'b0;
    st.rd_addr = prm_addr;
    st.wr_en   = prm_wr_en;
    st.wr_addr = prm_addr;
    st.wr_data = prm_wr_data;
    // Only the load captures into the active set; writes never touch it
    if (pend_q && !host_q) begin
      act_d[pend_idx_q] = st.rd_data;
    end
    case (st_q)
      SOA_LOAD: begin
        st.rd_en   = 1'b1;
        st.rd_addr = idx_q;
        pend_d     = 1'b1;
        pend_idx_d = idx_q;
        idx_d      = idx_q + 2'h1;
        if (idx_q == soa_pkg::LAST_IDX) begin
          st_d = SOA_RUN;
        end
      end
      SOA_RUN: begin
        // Host reads are refused while loading
        if (prm_rd_en) begin
          st.rd_en = 1'b1;
          pend_d   = 1'b1;
          host_d   = 1'b1;
        end
      end
      default: begin
        st_d = SOA_LOAD;
      end
    endcase
    rdv_d   = pend_q && host_q;
    ready_d = (st_q == SOA_RUN);
    // Outputs stay off until the active set is complete
    out_d   = ready_q ? (raw ^ act_q[soa_pkg::IDX_POLARITY][2:0]) : 3'h0;
    mon_d   = out_d;
    in_d    = sink_wiring ? ~seq_in_raw : seq_in_raw;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= SOA_LOAD;
      idx_q      <= 2'h0;
      pend_q     <= 1'b0;
      pend_idx_q <= 2'h0;
      host_q     <= 1'b0;
      for (int unsigned w = 0; w < soa_pkg::NUM_WORDS; w++) begin
        act_q[w] <= 16'h0000;
      end
      rdv_q      <= 1'b0;
      ready_q    <= 1'b0;
      out_q      <= 3'h0;
      mon_q      <= 3'h0;
      in_q       <= 8'h00;
    end else begin
      st_q       <= st_d;
      idx_q      <= idx_d;
      pend_q     <= pend_d;
      pend_idx_q <= pend_idx_d;
      host_q     <= host_d;
      act_q      <= act_d;
      rdv_q      <= rdv_d;
      ready_q    <= ready_d;
      out_q      <= out_d;
      mon_q      <= mon_d;
      in_q       <= in_d;
    end
  end

  assign prm_rd_data           = st.rd_data;
  assign prm_rd_valid          = rdv_q;
  assign cfg_ready             = ready_q;
  assign seq_out               = out_q;
  assign output_status_monitor = mon_q;
  assign seq_in_active         = in_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [15:0] sa, sb, sc, pol;
  assign sa  = act_q[soa_pkg::IDX_SEL_A];
  assign sb  = act_q[soa_pkg::IDX_SEL_B];
  assign sc  = act_q[soa_pkg::IDX_SEL_C];
  assign pol = act_q[soa_pkg::IDX_POLARITY];

  sequence s_warn_alone_out1;
    ready_q && sb[15:12] == 4'h1 && status_in == 10'h080 && status_valid[7] && !pol[0];
  endsequence

  a_warn_routes_one: assert property (s_warn_alone_out1 |=> seq_out[0])
    else $error("warning not routed to first output");
  a_zero_drives_none: assert property (ready_q && sa == 16'h0 && sb == 16'h0 && sc == 16'h0
    |=> seq_out == $past(pol[2:0]))
    else $error("unassigned selector drove an output");
  a_rotation_on_two: assert property (ready_q && sa[11:8] == 4'h2 && status_in == 10'h004
    && status_valid[2] && pol[2:0] == 3'h0 |=> seq_out == 3'h2)
    else $error("rotation detected not on second output");
  a_brake_on_two: assert property (ready_q && sb[11:8] == 4'h2 && status_in == 10'h040
    && status_valid[6] && !pol[1] |=> seq_out[1])
    else $error("brake interlock not on second output");
  a_invert_idle: assert property (ready_q && status_valid == 10'h0
    |=> seq_out == $past(pol[2:0]))
    else $error("inversion bits not applied to idle outputs");
  a_active_frozen: assert property (st_q == SOA_RUN && !(pend_q && !host_q)
    |=> $stable(sa) && $stable(sb) && $stable(sc) && $stable(pol))
    else $error("active routing changed without power cycle");
  a_monitor_match: assert property (output_status_monitor == seq_out)
    else $error("output monitor disagrees with outputs");
  a_sink_inverts: assert property (sink_wiring |=> seq_in_active == ~$past(seq_in_raw))
    else $error("sink wiring polarity wrong");
  a_source_direct: assert property (!sink_wiring |=> seq_in_active == $past(seq_in_raw))
    else $error("source wiring polarity wrong");
  a_or_shared: assert property (ready_q && sb[15:12] == 4'h3 && sc[3:0] == 4'h3
    && status_in == 10'h100 && status_valid[8] && !pol[2] |=> seq_out[2])
    else $error("shared output not ORed");
  a_invalid_quiet: assert property (ready_q && status_valid == 10'h0 && pol[2:0] == 3'h0
    |=> seq_out == 3'h0)
    else $error("invalid status asserted an output");
  a_invert_after_or: assert property (ready_q && sb[15:12] == 4'h1 && sc[3:0] == 4'h1
    && status_in == 10'h180 && (status_valid & 10'h180) == 10'h180 && pol[0]
    |=> !seq_out[0])
    else $error("inversion not applied after OR");
  a_load_bounded: assert property ($rose(rst_n) |-> ##[1:6] cfg_ready)
    else $error("active set not loaded in time");

endmodule : soa_allocator
`default_nettype wire

/* File: bench/soa_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Host controller on the connector: input contacts, output readers
// ****************************************************************
module soa_host_model (
  input  wire logic       core_clk,
  input  wire logic       sink_wiring,
  input  wire logic [7:0] want_on,
  input  wire logic [2:0] seq_out,
  output var  logic [7:0] seq_in_raw,
  output var  logic [2:0] pins_seen
);
  // Closed contact pulls low on sink wiring, high on source wiring
  always_comb seq_in_raw = sink_wiring ? ~want_on : want_on;
  // Host sees pins through its own input register
  always_ff @(posedge core_clk) pins_seen <= seq_out;
endmodule : soa_host_model
`default_nettype wire

/* File: bench/sequence_output_allocator_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module sequence_output_allocator_tb;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        core_clk, rst_n, store_rst_n, prm_wr_en, prm_rd_en, prm_rd_valid;
  logic        sink_wiring, cfg_ready;
  logic [1:0]  prm_addr;
  logic [15:0] prm_wr_data, prm_rd_data;
  logic [9:0]  status_in, status_valid;
  logic [7:0]  seq_in_raw, seq_in_active, want_on;
  logic [2:0]  seq_out, output_status_monitor, pins_seen;
  int          mismatches, checks, cycles;
  localparam logic [9:0] ALL = 10'h3ff;
  localparam logic [9:0] ROT = 10'h1 << soa_pkg::ST_ROTATION;
  localparam logic [9:0] BRK = 10'h1 << soa_pkg::ST_BRAKE;
  localparam logic [9:0] WRN = 10'h1 << soa_pkg::ST_WARNING;
  localparam logic [9:0] NER = 10'h1 << soa_pkg::ST_NEAR;
  localparam logic [9:0] PLS = 10'h1 << soa_pkg::ST_PULSE_MULT;

  soa_allocator dut (.core_clk(core_clk), .rst_n(rst_n), .store_rst_n(store_rst_n),
    .prm_wr_en(prm_wr_en), .prm_addr(prm_addr), .prm_wr_data(prm_wr_data),
    .prm_rd_en(prm_rd_en), .prm_rd_data(prm_rd_data), .prm_rd_valid(prm_rd_valid),
    .status_in(status_in), .status_valid(status_valid), .sink_wiring(sink_wiring),
    .seq_in_raw(seq_in_raw), .seq_in_active(seq_in_active), .seq_out(seq_out),
    .output_status_monitor(output_status_monitor), .cfg_ready(cfg_ready));
  soa_host_model host (.core_clk(core_clk), .sink_wiring(sink_wiring), .want_on(want_on),
    .seq_out(seq_out), .seq_in_raw(seq_in_raw), .pins_seen(pins_seen));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick();
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : tick
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic wait_ready();
    int n;
    n = 0;
    while (cfg_ready !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    `CHK(cfg_ready, 1'b1)
  endtask : wait_ready
  // Power cycle: the only way new routing takes over
  task automatic pwr();
    rst_n = 1'b0;
    tick();
    rst_n = 1'b1;
    wait_ready();
  endtask : pwr
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    prm_wr_en = 1'b1;
    prm_addr = a;
    prm_wr_data = d;
    tick();
    prm_wr_en = 1'b0;
    // Idle cycle so a following request never reuses this time step
    tick();
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    int n;
    prm_rd_en = 1'b1;
    prm_addr = a;
    tick();
    prm_rd_en = 1'b0;
    n = 0;
    while (prm_rd_valid !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    `CHK(prm_rd_valid, 1'b1)
    `CHK(prm_rd_data, exp)
  endtask : rd
  task automatic route(input logic [9:0] st, input logic [9:0] vl, input logic [2:0] exp);
    status_in = st;
    status_valid = vl;
    tick();
    `CHK(seq_out, exp)
    `CHK(output_status_monitor, exp)
    tick();
    `CHK(pins_seen, exp)
  endtask : route

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_factory();
    rd(soa_pkg::IDX_SEL_A, soa_pkg::RST_SEL_A);
    rd(soa_pkg::IDX_SEL_B, soa_pkg::RST_SEL_B);
    rd(soa_pkg::IDX_SEL_C, soa_pkg::RST_SEL_C);
    rd(soa_pkg::IDX_POLARITY, soa_pkg::RST_POLARITY);
    route(ROT, ALL, 3'h2);
    route(ALL & ~ROT, ALL, 3'h0);
    $display("test factory done");
  endtask : t_factory
  task automatic t_defer();
    wr(soa_pkg::IDX_SEL_A, 16'h0000);
    wr(soa_pkg::IDX_SEL_B, 16'h0200);
    route(BRK, ALL, 3'h0);
    route(ROT, ALL, 3'h2);
    rd(soa_pkg::IDX_SEL_B, 16'h0200);
    pwr();
    route(ROT, ALL, 3'h0);
    route(BRK, ALL, 3'h2);
    $display("test defer done");
  endtask : t_defer
  task automatic t_select();
    logic [3:0] s;
    logic [2:0] e;
    for (int i = 0; i < 5; i++) begin
      s = i[3:0];
      e = (i >= 1 && i <= 3) ? 3'h1 << (i - 1) : 3'h0;
      wr(soa_pkg::IDX_SEL_B, {s, 12'h000});
      wr(soa_pkg::IDX_SEL_C, {4'h0, s, 4'h0, s});
      pwr();
      route(WRN, ALL, e);
      route(NER, ALL, e);
      route(PLS, ALL, e);
    end
    $display("test select done");
  endtask : t_select
  task automatic t_or_pol();
    wr(soa_pkg::IDX_SEL_B, 16'h1000);
    wr(soa_pkg::IDX_SEL_C, 16'h0301);
    wr(soa_pkg::IDX_POLARITY, 16'h0005);
    pwr();
    route(10'h000, ALL, 3'h5);
    route(WRN | NER, ALL, 3'h4);
    route(PLS, ALL, 3'h1);
    route(WRN | PLS, ALL & ~(WRN | PLS), 3'h5);
    wr(soa_pkg::IDX_POLARITY, 16'h0000);
    $display("test or_pol done");
  endtask : t_or_pol
  task automatic t_refuse();
    rst_n = 1'b0;
    tick();
    `CHK(seq_out, 3'h0)
    rst_n = 1'b1;
    prm_rd_en = 1'b1;
    tick();
    prm_rd_en = 1'b0;
    for (int i = 0; i < 3; i++) begin
      tick();
      `CHK(prm_rd_valid, 1'b0)
    end
    wait_ready();
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_inputs();
    for (int w = 0; w < 2; w++) begin
      sink_wiring = w[0];
      want_on = w[0] ? 8'ha5 : 8'h3c;
      tick();
      tick();
      `CHK(seq_in_active, want_on)
    end
    $display("test inputs done");
  endtask : t_inputs

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Whole run is well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {mismatches, checks, cycles} = '0;
    {rst_n, store_rst_n, prm_wr_en, prm_rd_en, sink_wiring} = '0;
    {prm_addr, prm_wr_data, status_in, status_valid, want_on} = '0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    store_rst_n = 1'b1;
    wait_ready();
    t_factory();
    t_defer();
    t_select();
    t_or_pol();
    t_refuse();
    t_inputs();
    give_verdict();
  end
endmodule : sequence_output_allocator_tb
`default_nettype wire
